// *** sfhp_buf2.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes clk_in and a synchronous active-high reset_in shared with the source and sink.
`timescale 1ns/10ps
module sfhp_buf2
    import sfhp_pkg::*;
(
    input  wire logic  clk_in,
    input  wire logic  reset_in,
    sfhp_stream_if.snk fill_s,
    sfhp_stream_if.src drain_s
);

    logic [DATA_W-1:0] mem_r [BUF_DEPTH];
    logic [DATA_W-1:0] mem_nxt [BUF_DEPTH];
    logic              wr_ptr_r, wr_ptr_nxt;
    logic              rd_ptr_r, rd_ptr_nxt;
    logic [1:0]        count_r, count_nxt;
    logic              push;
    logic              pop;

    // Ready and valid come from the count register only, never from the far side
    assign fill_s.ready  = (count_r != 2'(BUF_DEPTH));
    assign drain_s.valid = (count_r != 2'h0);
    assign drain_s.data  = mem_r[rd_ptr_r];
    assign push          = fill_s.valid && fill_s.ready;
    assign pop           = drain_s.valid && drain_s.ready;

    always_comb begin
        mem_nxt    = mem_r;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt  = count_r;
        if (push) begin
            mem_nxt[wr_ptr_r] = fill_s.data;
            wr_ptr_nxt        = !wr_ptr_r;
        end
        if (pop) begin
            rd_ptr_nxt = !rd_ptr_r;
        end
        if (push && !pop) begin
            count_nxt = count_r + 2'h1;
        end else if (pop && !push) begin
            count_nxt = count_r - 2'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                mem_r[i] <= DATA_RST;
            end
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
            mem_r    <= mem_nxt;
        end
    end

    buf_bound_a: assert property (@(posedge clk_in) disable iff (reset_in)
        count_r <= 2'(BUF_DEPTH))
        else $error("buffer count above depth");

endmodule : sfhp_buf2

// *** sfhp_far_model.sv ***
// Far-side bus master model: reads and writes the parallel port at port clock rises.
// Assumes the bench resolves the shared data bus and feeds it back on bus_in.
`timescale 1ns/10ps
module sfhp_far_model
    import sfhp_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    input  wire logic              port_clock_in,
    input  wire logic              rx_data_avail_n_in,
    input  wire logic              tx_space_avail_n_in,
    input  wire logic [DATA_W-1:0] bus_in,
    input  wire logic              read_en_in,
    input  wire logic [3:0]        write_count_in,
    input  wire logic              strobe_in,
    output logic                   read_n_out,
    output logic                   write_n_out,
    output logic                   output_enable_n_out,
    output logic                   send_now_wakeup_n_out,
    output logic      [DATA_W-1:0] bus_out
);
    logic [DATA_W-1:0] got_q[$];
    logic [3:0]        sent_r;
    logic [3:0]        n;
    logic              rd_prev_r;
    logic              wr_prev_r;

    // ********
    // Port clock rise: a system edge that still sees the port clock low
    // ********
    // The port sees its pins two port edges late, so a byte moves with the strobe driven two edges back
    always @(posedge clk_in) begin
        if (reset_in) begin
            read_n_out            <= 1'b1;
            write_n_out           <= 1'b1;
            output_enable_n_out   <= 1'b1;
            send_now_wakeup_n_out <= 1'b1;
            bus_out               <= 8'h00;
            sent_r                <= 4'h0;
            rd_prev_r             <= 1'b1;
            wr_prev_r             <= 1'b1;
        end else if (!port_clock_in) begin
            if (!rd_prev_r && !rx_data_avail_n_in)
                got_q.push_back(bus_in);
            n = sent_r + 4'(!wr_prev_r && !tx_space_avail_n_in);
            sent_r    <= n;
            rd_prev_r <= read_n_out;
            wr_prev_r <= write_n_out;
            output_enable_n_out <= !read_en_in;
            // A read only starts on a low flag, a port period after the enable
            read_n_out <= !(read_en_in && !output_enable_n_out
                            && (!read_n_out || !rx_data_avail_n_in));
            send_now_wakeup_n_out <= !strobe_in;
            // One write in flight: the next byte waits until the last is known taken or dropped
            if (n < write_count_in && write_n_out && !tx_space_avail_n_in && output_enable_n_out) begin
                write_n_out <= 1'b0;
                bus_out     <= 8'h30 + 8'(n);
            end else begin
                write_n_out <= 1'b1;
                // Released bus toggles so no stale byte can pass for data
                bus_out     <= ~bus_out;
            end
        end
    end
endmodule : sfhp_far_model

// *** sfhp_pkg.sv ***
// Shared constants for the synchronous parallel FIFO host port.
// Assumes a single 100 MHz system clock; no other file defines these names.
package sfhp_pkg;

    // ****************************************
    // Widths and depths
    // ****************************************
    localparam int DATA_W    = 8;
    localparam int BUF_DEPTH = 2;
    localparam int PIN_W     = 12;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SYS_CLK_MHZ  = 100;
    localparam int PORT_CLK_MHZ = 60;
    // Half period of the port clock in system cycles, rounded down, at least one
    localparam int PORT_HALF_INT = (SYS_CLK_MHZ / (2 * PORT_CLK_MHZ)) < 1 ? 1
                                 : (SYS_CLK_MHZ / (2 * PORT_CLK_MHZ));
    localparam logic [3:0] PORT_HALF_CNT = 4'(PORT_HALF_INT);
    localparam logic [3:0] DIV_STEP      = 4'h1;
    localparam logic [3:0] DIV_RST       = 4'h0;

    // ****************************************
    // Pin sample layout and reset values
    // ****************************************
    localparam int PIN_RD   = 11;
    localparam int PIN_WR   = 10;
    localparam int PIN_OE   = 9;
    localparam int PIN_SEND_NOW_WAKEUP_N = 8;
    localparam int PIN_D_HI = 7;
    localparam int PIN_D_LO = 0;
    localparam logic [PIN_W-1:0]  PIN_IDLE = 12'hf00;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic              FLAG_OFF = 1'b1;

endpackage : sfhp_pkg

// *** sfhp_port.sv ***
// Synchronous parallel FIFO host port: byte streams to and from an external bus master.
// Assumes pins arrive asynchronously; user streams and USB status come from clk_in logic.
`timescale 1ns/10ps

// Contract
// - FIFO port lives on the first channel only; second channel disabled while active.
// - Mode entered only when configuration selects FIFO and a mode command arrives.
// - Every byte moves on a rising edge of the port clock.
// - Device drives a free-running port clock; far side syncs to it.
// - Data bus is input unless output enable is held low.
// - Data-available low only with a receive byte present; far side reads only then.
// - One receive byte moves on each edge with data-available and read both low.
// - Current byte shown when read falls; next byte every clock while read low.
// - Space-available low only when transmit buffer has room; far side writes only then.
// - One byte accepted on each edge with space-available and write both low.
// - While write is low a bus byte is captured every clock.
// - Suspended with wakeup enabled: send-now strobe requests bus resume.
// - Powered: send-now strobe flushes buffered transmit data on next bulk-in.
// - Power enable low when configured and awake, high otherwise.
module sfhp_port
    import sfhp_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    input  wire logic              cfg_fifo_mode_in,
    input  wire logic              mode_cmd_in,
    input  wire logic              remote_wakeup_en_in,
    input  wire logic              usb_configured_in,
    input  wire logic              usb_suspend_in,
    input  wire logic [DATA_W-1:0] rx_data_in,
    input  wire logic              rx_valid_in,
    output logic                   rx_ready_out,
    output logic      [DATA_W-1:0] tx_data_out,
    output logic                   tx_valid_out,
    input  wire logic              tx_ready_in,
    output logic                   interface_clock_out,
    output logic                   rx_data_avail_n_out,
    output logic                   tx_space_avail_n_out,
    input  wire logic              read_n_in,
    input  wire logic              write_n_in,
    input  wire logic              output_enable_n_in,
    input  wire logic              send_now_wakeup_n_in,
    input  wire logic [DATA_W-1:0] port_data_bus_in,
    output logic      [DATA_W-1:0] port_data_bus_out,
    output logic                   port_data_bus_oe_out,
    output logic                   power_enable_n_out,
    output logic                   resume_req_out,
    output logic                   send_now_out,
    output logic                   sync_mode_out,
    output logic                   chan_b_enable_out
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [PIN_W-1:0] pin_s1_r, pin_s2_r;
    logic             send_now_wakeup_n_s3_r;
    logic             rd_n_s, wr_n_s, oe_n_s;
    logic [DATA_W-1:0] bus_s;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pin_s1_r  <= PIN_IDLE;
            pin_s2_r  <= PIN_IDLE;
            send_now_wakeup_n_s3_r <= FLAG_OFF;
        end else begin
            pin_s1_r  <= {read_n_in, write_n_in, output_enable_n_in, send_now_wakeup_n_in, port_data_bus_in};
            pin_s2_r  <= pin_s1_r;
            send_now_wakeup_n_s3_r <= pin_s2_r[PIN_SEND_NOW_WAKEUP_N];
        end
    end

    assign rd_n_s = pin_s2_r[PIN_RD];
    assign wr_n_s = pin_s2_r[PIN_WR];
    assign oe_n_s = pin_s2_r[PIN_OE];
    assign bus_s  = pin_s2_r[PIN_D_HI:PIN_D_LO];

    // ****************************************
    // Port clock divider
    // ****************************************
    // 60 MHz cannot be reached from 100 MHz by an integer divider; the half
    // period rounds down and is held at one cycle, so the port clock runs at 50 MHz, slower than 60 MHz.
    logic [3:0] div_r, div_nxt;
    logic       pclk_r, pclk_nxt;
    logic       tick;
    logic       port_edge;

    assign tick      = (div_r == PORT_HALF_CNT - DIV_STEP);
    assign port_edge = tick && !pclk_r;

    always_comb begin
        div_nxt  = tick ? DIV_RST : div_r + DIV_STEP;
        pclk_nxt = tick ? !pclk_r : pclk_r;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            div_r  <= DIV_RST;
            pclk_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            pclk_r <= pclk_nxt;
        end
    end

    assign interface_clock_out = pclk_r;

    // ****************************************
    // Mode, power and send-now/wakeup
    // ****************************************
    logic mode_r, mode_nxt;
    logic chan_b_r, chan_b_nxt;
    logic power_enable_n_n_r, power_enable_n_n_nxt;
    logic resume_r, resume_nxt;
    logic send_r, send_nxt;
    logic send_now_wakeup_n_fall;

    assign send_now_wakeup_n_fall = send_now_wakeup_n_s3_r && !pin_s2_r[PIN_SEND_NOW_WAKEUP_N];

    always_comb begin
        mode_nxt    = mode_cmd_in ? cfg_fifo_mode_in : mode_r;
        chan_b_nxt  = !mode_nxt;
        power_enable_n_n_nxt = !(usb_configured_in && !usb_suspend_in);
        resume_nxt  = send_now_wakeup_n_fall && mode_r && power_enable_n_n_r && remote_wakeup_en_in;
        send_nxt    = send_now_wakeup_n_fall && mode_r && !power_enable_n_n_r;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mode_r    <= 1'b0;
            chan_b_r  <= 1'b1;
            power_enable_n_n_r <= FLAG_OFF;
            resume_r  <= 1'b0;
            send_r    <= 1'b0;
        end else begin
            mode_r    <= mode_nxt;
            chan_b_r  <= chan_b_nxt;
            power_enable_n_n_r <= power_enable_n_n_nxt;
            resume_r  <= resume_nxt;
            send_r    <= send_nxt;
        end
    end

    assign sync_mode_out      = mode_r;
    assign chan_b_enable_out  = chan_b_r;
    assign power_enable_n_out = power_enable_n_n_r;
    assign resume_req_out     = resume_r;
    assign send_now_out       = send_r;

    // ****************************************
    // Receive path: USB side to bus
    // ****************************************
    logic [DATA_W-1:0] cur_data_r, cur_data_nxt;
    logic              cur_valid_r, cur_valid_nxt;
    logic              rx_ready_r, rx_ready_nxt;
    logic              avail_n_r, avail_n_nxt;
    logic [DATA_W-1:0] pdata_r, pdata_nxt;
    logic              poe_r, poe_nxt;
    logic              rx_take;
    logic              rx_xfer;

    assign rx_take = rx_valid_in && rx_ready_r;
    assign rx_xfer = port_edge && !avail_n_r && !rd_n_s;

    // Refill lands one cycle after a transfer, so a byte is ready by the next port edge
    always_comb begin
        cur_valid_nxt = cur_valid_r;
        cur_data_nxt  = cur_data_r;
        if (rx_xfer) begin
            cur_valid_nxt = 1'b0;
        end
        if (rx_take) begin
            cur_valid_nxt = 1'b1;
            cur_data_nxt  = rx_data_in;
        end
        rx_ready_nxt = mode_nxt && !cur_valid_nxt;
        avail_n_nxt  = !(mode_nxt && cur_valid_nxt);
        pdata_nxt    = cur_data_nxt;
        poe_nxt      = mode_r && !oe_n_s;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cur_data_r  <= DATA_RST;
            cur_valid_r <= 1'b0;
            rx_ready_r  <= 1'b0;
            avail_n_r   <= FLAG_OFF;
            pdata_r     <= DATA_RST;
            poe_r       <= 1'b0;
        end else begin
            cur_data_r  <= cur_data_nxt;
            cur_valid_r <= cur_valid_nxt;
            rx_ready_r  <= rx_ready_nxt;
            avail_n_r   <= avail_n_nxt;
            pdata_r     <= pdata_nxt;
            poe_r       <= poe_nxt;
        end
    end

    assign rx_ready_out         = rx_ready_r;
    assign rx_data_avail_n_out  = avail_n_r;
    assign port_data_bus_out    = pdata_r;
    assign port_data_bus_oe_out = poe_r;

    // ****************************************
    // Transmit path: bus to USB side
    // ****************************************
    sfhp_stream_if tx_fill ();
    sfhp_stream_if tx_drain ();

    sfhp_buf2 u_tx_buf (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .fill_s   (tx_fill),
        .drain_s  (tx_drain)
    );

    logic              space_n_r, space_n_nxt;
    logic              txv_r, txv_nxt;
    logic [DATA_W-1:0] txd_r, txd_nxt;
    logic              tx_xfer;
    logic              stage_free;

    // Buffer ready gates the capture too, so a late flag can never overrun it
    assign tx_xfer        = port_edge && !space_n_r && !wr_n_s && tx_fill.ready;
    assign tx_fill.valid  = tx_xfer;
    assign tx_fill.data   = bus_s;
    assign stage_free     = !txv_r || tx_ready_in;
    assign tx_drain.ready = stage_free;

    always_comb begin
        // Flag goes high for a cycle after each capture until the count settles
        space_n_nxt = !(mode_nxt && tx_fill.ready && !tx_xfer);
        txv_nxt     = stage_free ? tx_drain.valid : txv_r;
        txd_nxt     = (stage_free && tx_drain.valid) ? tx_drain.data : txd_r;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            space_n_r <= FLAG_OFF;
            txv_r     <= 1'b0;
            txd_r     <= DATA_RST;
        end else begin
            space_n_r <= space_n_nxt;
            txv_r     <= txv_nxt;
            txd_r     <= txd_nxt;
        end
    end

    assign tx_space_avail_n_out = space_n_r;
    assign tx_valid_out         = txv_r;
    assign tx_data_out          = txd_r;

    // ****************************************
    // Checks
    // ****************************************
    chan_b_off_a: assert property (@(posedge clk_in) disable iff (reset_in)
        mode_r |-> !chan_b_enable_out)
        else $error("second channel enabled in FIFO mode");
    mode_entry_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $rose(mode_r) |-> $past(mode_cmd_in) && $past(cfg_fifo_mode_in))
        else $error("FIFO mode entered without command");
    port_clock_a: assert property (@(posedge clk_in) disable iff (reset_in)
        port_edge |=> interface_clock_out ##1 !interface_clock_out)
        else $error("port clock not toggling");
    bus_drive_a: assert property (@(posedge clk_in) disable iff (reset_in)
        port_data_bus_oe_out |-> $past(oe_n_s) == 1'b0)
        else $error("bus driven without output enable");
    rx_flag_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !rx_data_avail_n_out |-> cur_valid_r && port_data_bus_out == cur_data_r)
        else $error("data flag low with no byte");
    rx_advance_a: assert property (@(posedge clk_in) disable iff (reset_in)
        rx_xfer && !rx_take |=> !cur_valid_r)
        else $error("receive byte not consumed");
    tx_flag_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !tx_space_avail_n_out |-> tx_fill.ready)
        else $error("space flag low with buffer full");
    tx_capture_a: assert property (@(posedge clk_in) disable iff (reset_in)
        port_edge && !tx_space_avail_n_out && !wr_n_s |-> tx_fill.valid && tx_fill.data == bus_s)
        else $error("write byte not captured");
    wake_req_a: assert property (@(posedge clk_in) disable iff (reset_in)
        send_now_wakeup_n_fall && mode_r && power_enable_n_out && remote_wakeup_en_in |=> resume_req_out && !send_now_out)
        else $error("resume not requested");
    send_now_a: assert property (@(posedge clk_in) disable iff (reset_in)
        send_now_wakeup_n_fall && mode_r && !power_enable_n_out |=> send_now_out && !resume_req_out)
        else $error("send-now not issued");
    power_state_a: assert property (@(posedge clk_in) disable iff (reset_in)
        1'b1 |=> power_enable_n_out == !($past(usb_configured_in) && !$past(usb_suspend_in)))
        else $error("power enable wrong");
    flags_idle_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !mode_r |-> rx_data_avail_n_out && tx_space_avail_n_out)
        else $error("flags low outside FIFO mode");

endmodule : sfhp_port

// *** sfhp_stream_if.sv ***
// Byte stream carrier with valid and ready between the port's own modules.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface sfhp_stream_if;
    import sfhp_pkg::*;
    logic              valid;
    logic              ready;
    logic [DATA_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sfhp_stream_if

// *** sync_fifo_host_port_bench.sv ***
// Self-checking bench for the synchronous parallel FIFO host port.
// Assumes the package, stream interface, buffer, port and far model are compiled first.
`timescale 1ns/10ps
module sync_fifo_host_port_bench;
    import sfhp_pkg::*;

    logic              clk_in = 1'b0;
    logic              reset_in = 1'b1;
    logic              cfg_fifo, mode_cmd, wake_en, configured, suspend, read_en, strobe;
    logic              rx_valid, rx_ready, tx_valid, tx_ready, pclk, avail_n, space_n;
    logic              rd_n, wr_n, oe_n, send_now_wakeup_n_n, dut_oe, power_enable_n_n, resume, send_now, sync_mode, chan_b;
    logic [3:0]        wr_count;
    logic [DATA_W-1:0] rx_data, tx_data, dut_bus, far_bus, bus_wire;
    logic [DATA_W-1:0] rx_src[$];
    logic [DATA_W-1:0] tx_got[$];
    int                mismatches, compares;

    always #5 clk_in = ~clk_in;
    assign bus_wire = dut_oe ? dut_bus : far_bus;

    sfhp_port u_dut (.clk_in(clk_in), .reset_in(reset_in), .cfg_fifo_mode_in(cfg_fifo),
        .mode_cmd_in(mode_cmd), .remote_wakeup_en_in(wake_en), .usb_configured_in(configured),
        .usb_suspend_in(suspend), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
        .rx_ready_out(rx_ready), .tx_data_out(tx_data), .tx_valid_out(tx_valid),
        .tx_ready_in(tx_ready), .interface_clock_out(pclk), .rx_data_avail_n_out(avail_n),
        .tx_space_avail_n_out(space_n), .read_n_in(rd_n), .write_n_in(wr_n),
        .output_enable_n_in(oe_n), .send_now_wakeup_n_in(send_now_wakeup_n_n), .port_data_bus_in(bus_wire),
        .port_data_bus_out(dut_bus), .port_data_bus_oe_out(dut_oe), .power_enable_n_out(power_enable_n_n),
        .resume_req_out(resume), .send_now_out(send_now), .sync_mode_out(sync_mode),
        .chan_b_enable_out(chan_b));

    sfhp_far_model u_far (.clk_in(clk_in), .reset_in(reset_in), .port_clock_in(pclk),
        .rx_data_avail_n_in(avail_n), .tx_space_avail_n_in(space_n), .bus_in(bus_wire),
        .read_en_in(read_en), .write_count_in(wr_count), .strobe_in(strobe),
        .read_n_out(rd_n), .write_n_out(wr_n), .output_enable_n_out(oe_n),
        .send_now_wakeup_n_out(send_now_wakeup_n_n), .bus_out(far_bus));

    // ********
    // USB-side byte source and sink
    // ********
    always @(posedge clk_in) begin
        if (rx_valid && rx_ready)
            void'(rx_src.pop_front());
        rx_valid <= rx_src.size() > 0;
        rx_data  <= rx_src.size() > 0 ? rx_src[0] : 8'h00;
        if (tx_valid && tx_ready)
            tx_got.push_back(tx_data);
    end

    // ********
    // Checking and closing
    // ********
    task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task finish_test;
        $display("Counts: %0d mismatches, %0d compares", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task give_up(input string what);
        mismatches++;
        $display("CHECK FAILED at %0t: %s timed out", $time, what);
        finish_test();
    endtask : give_up

    // ********
    // Scenarios
    // ********
    task t_reset;
        @(posedge clk_in);
        #1;
        check(8'(avail_n), 8'h01, "data flag after reset");
        check(8'(space_n), 8'h01, "space flag after reset");
        check(8'(rx_ready), 8'h00, "receive ready after reset");
        check(8'(dut_oe), 8'h00, "bus drive after reset");
        check(8'(power_enable_n_n), 8'h01, "power enable unconfigured");
    endtask : t_reset

    task t_mode;
        @(posedge clk_in);
        mode_cmd <= 1'b1;
        @(posedge clk_in);
        mode_cmd <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        check(8'(sync_mode), 8'h00, "mode without config");
        check(8'(chan_b), 8'h01, "second channel kept");
        @(posedge clk_in);
        cfg_fifo <= 1'b1;
        mode_cmd <= 1'b1;
        @(posedge clk_in);
        mode_cmd <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        check(8'(sync_mode), 8'h01, "mode entered");
        check(8'(chan_b), 8'h00, "second channel off");
        check(8'(avail_n), 8'h01, "data flag empty");
        check(8'(space_n), 8'h00, "space flag room");
    endtask : t_mode

    task t_clock;
        int  t;
        logic last;
        t = 0;
        @(posedge clk_in);
        #1;
        last = pclk;
        repeat (20) begin
            @(posedge clk_in);
            #1;
            t += (pclk !== last);
            last = pclk;
        end
        check(8'(t), 8'h14, "port clock toggles");
    endtask : t_clock

    task t_power;
        @(posedge clk_in);
        configured <= 1'b1;
        @(posedge clk_in);
        #1;
        check(8'(power_enable_n_n), 8'h00, "power enable configured");
    endtask : t_power

    task t_read;
        int n;
        logic [DATA_W-1:0] want[$];
        want = '{8'ha5, 8'h5a, 8'h01, 8'hfe, 8'h80};
        rx_src = want;
        @(posedge clk_in);
        read_en <= 1'b1;
        for (n = 0; n < 300 && u_far.got_q.size() < 5; n++)
            @(posedge clk_in);
        if (n == 300)
            give_up("read burst");
        read_en <= 1'b0;
        #1;
        check(8'(dut_oe), 8'h01, "bus driven in read");
        for (n = 0; n < 5; n++)
            check(u_far.got_q[n], want[n], "read byte");
        repeat (10) @(posedge clk_in);
        #1;
        check(8'(dut_oe), 8'h00, "bus released");
        check(8'(avail_n), 8'h01, "data flag drained");
    endtask : t_read

    task t_write;
        int n;
        @(posedge clk_in);
        wr_count <= 4'h5;
        repeat (40) @(posedge clk_in);
        #1;
        check(8'(space_n), 8'h01, "space flag full");
        check(8'(u_far.sent_r), 8'h03, "bytes taken while stalled");
        check(8'(tx_valid), 8'h01, "first byte offered");
        check(tx_data, 8'h30, "first byte held");
        @(posedge clk_in);
        tx_ready <= 1'b1;
        for (n = 0; n < 300 && tx_got.size() < 5; n++)
            @(posedge clk_in);
        if (n == 300)
            give_up("write burst");
        for (n = 0; n < 5; n++)
            check(tx_got[n], 8'h30 + 8'(n), "written byte");
    endtask : t_write

    task send_now_wakeup_n_try(input logic [DATA_W-1:0] exp_send, input logic [DATA_W-1:0] exp_res);
        int s, r;
        s = 0;
        r = 0;
        @(posedge clk_in);
        strobe <= 1'b1;
        repeat (2) @(posedge clk_in);
        strobe <= 1'b0;
        repeat (20) begin
            @(posedge clk_in);
            #1;
            s += (send_now === 1'b1);
            r += (resume === 1'b1);
        end
        check(8'(s), exp_send, "send-now pulses");
        check(8'(r), exp_res, "resume pulses");
    endtask : send_now_wakeup_n_try

    task t_wake;
        send_now_wakeup_n_try(8'h01, 8'h00);
        @(posedge clk_in);
        suspend <= 1'b1;
        wake_en <= 1'b1;
        @(posedge clk_in);
        #1;
        check(8'(power_enable_n_n), 8'h01, "power enable suspended");
        send_now_wakeup_n_try(8'h00, 8'h01);
        @(posedge clk_in);
        wake_en <= 1'b0;
        send_now_wakeup_n_try(8'h00, 8'h00);
    endtask : t_wake

    initial begin
        {cfg_fifo, mode_cmd, wake_en, configured, suspend} = 5'h00;
        {rx_valid, tx_ready, read_en, strobe} = 4'h0;
        wr_count = 4'h0;
        rx_data = 8'h00;
        mismatches = 0;
        compares = 0;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        t_reset();
        t_mode();
        t_clock();
        t_power();
        t_read();
        t_write();
        t_wake();
        finish_test();
    end
endmodule : sync_fifo_host_port_bench
